// ==== verilog/eecl_top.sv ====
// nonvolatile byte store with row programming, plus boot configuration latches
// assumes APB master on the register side and a processor data read port
// Behaviour
// RULE_01 - 128 rows of 16 bytes, byte addressed
// RULE_02 - direct reads, writes only by command
// RULE_03 - erase and write whole rows only
// RULE_04 - flash execution continues during store writes
// RULE_05 - factory value of every byte is zero
// RULE_06 - no hardware error correction on store
// RULE_07 - data space only, no instruction fetch
// RULE_08 - one write lasts up to 20 ms
// RULE_09 - no reset during a nonvolatile write
// RULE_10 - low voltage should interrupt, not reset
// RULE_11 - four latch bytes applied at every reset
// RULE_12 - port drive mode shared by whole port
// RULE_13 - reset select bit: gpio or reset pin
// RULE_14 - debug access bit, default enabled
// RULE_15 - debug port select field encoding
// RULE_16 - ecc bit reserves or frees extra region
// RULE_17 - four-bit digital clock phase delay
// RULE_18 - limit latch erase and rewrite cycles
// RULE_19 - latches loaded before processor reset release
// RULE_20 - ecc corrects one, detects two bits
`timescale 1ns/1ps
module eecl_top
  import eecl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  nv_factory_init,
  input  wire eecl_apb_req_s         apb_req,
  output eecl_apb_rsp_s              apb_rsp,
  input  wire logic                  rd_en,
  input  wire logic                  rd_fetch,
  input  wire logic [ADDR_W-1:0]     rd_addr,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  output logic                       rd_fetch_err,
  output logic                       store_busy,
  output logic                       cpu_reset_hold,
  output eecl_boot_cfg_s             boot_cfg
);

  eecl_state_s q;
  eecl_state_s d;

  logic [9:0] idx;
  logic       setup;
  logic       access;
  logic       wr_acc;
  logic       map_hit;
  logic       busy_err;
  logic [1:0] cmd;
  logic [3:0] idx_next;

  assign idx      = apb_req.paddr[PADDR_W-1:2];
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign access   = apb_req.psel & apb_req.penable;
  assign wr_acc   = access & apb_req.pwrite & ~q.pslverr;
  assign cmd      = apb_req.pwdata[1:0];
  assign idx_next = q.idx + 4'h1;

  assign map_hit = (idx <= IDX_STATUS) && (apb_req.paddr[1:0] == 2'b00);

  // store commands and buffer loads are refused while a row write runs
  always_comb begin
    busy_err = 1'b0;
    if (apb_req.pwrite && q.busy &&
        (idx == IDX_ROW || idx == IDX_DATA || idx == IDX_CMD)) begin
      busy_err = 1'b1;
    end
    if (apb_req.pwrite && idx == IDX_CMD && cmd != CMD_ERASE && cmd != CMD_WRITE) begin
      busy_err = 1'b1;
    end
  end

  always_comb begin
    d = q;
    d.rd_valid     = 1'b0;
    d.rd_fetch_err = 1'b0;

    // store is only on the data side; a fetch gets zero and an error
    if (rd_en) begin
      d.rd_valid = 1'b1;
      if (rd_fetch) begin
        d.rd_data      = 8'h00;                                       // [RULE_07]
        d.rd_fetch_err = 1'b1;                                        // [RULE_07]
      end else begin
        // direct byte read, no correction applied
        d.rd_data = q.mem[rd_addr[ADDR_W-1:4]][rd_addr[3:0]]; // [RULE_01] [RULE_02] [RULE_06]
      end
    end

    // read data and error are captured in the setup cycle, zero wait
    if (setup) begin
      d.pslverr = ~map_hit | busy_err;
      d.prdata  = 32'h0000_0000;
      if (map_hit && !apb_req.pwrite) begin
        unique case (idx)
          IDX_LATCH0: d.prdata[7:0] = q.latch[0];
          IDX_LATCH1: d.prdata[7:0] = q.latch[1];
          IDX_LATCH2: d.prdata[7:0] = q.latch[2];
          IDX_LATCH3: d.prdata[7:0] = q.latch[3];
          IDX_ROW:    d.prdata[6:0] = q.row;
          IDX_STATUS: begin
            d.prdata[ST_BUSY]           = q.busy;
            d.prdata[ST_DONE]           = q.done;
            d.prdata[ST_IDX+3:ST_IDX]   = q.idx;
          end
          default:    d.prdata = 32'h0000_0000;
        endcase
      end
    end

    // row write timer; reads and fetches elsewhere are never stalled
    if (q.busy) begin                                                 // [RULE_04]
      if (q.cnt == '0) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        // whole row replaced, never a single byte
        if (q.erase) begin
          d.mem[q.row] = {ROW_BYTES{MEM_RST}};                        // [RULE_03]
        end else begin
          d.mem[q.row] = q.rowbuf;                                    // [RULE_03]
        end
      end else begin
        d.cnt = q.cnt - 1'b1;                                         // [RULE_08]
      end
    end

    if (wr_acc && map_hit) begin
      unique case (idx)
        // new latch values take hold only at the next reset
        IDX_LATCH0: d.latch[0] = apb_req.pwdata[7:0];                 // [RULE_11]
        IDX_LATCH1: d.latch[1] = apb_req.pwdata[7:0];                 // [RULE_11]
        IDX_LATCH2: d.latch[2] = apb_req.pwdata[7:0];                 // [RULE_11]
        IDX_LATCH3: d.latch[3] = apb_req.pwdata[7:0];                 // [RULE_11]
        IDX_ROW: begin
          d.row = apb_req.pwdata[6:0];
          d.idx = 4'h0;
        end
        IDX_DATA: begin
          // byte writes only fill the row buffer
          d.rowbuf[q.idx] = apb_req.pwdata[7:0];                      // [RULE_02]
          d.idx           = idx_next;
        end
        IDX_CMD: begin
          d.busy  = 1'b1;                                             // [RULE_02]
          d.erase = (cmd == CMD_ERASE);
          d.cnt   = CNT_W'(WRITE_CYCLES_P - 1);                       // [RULE_08]
        end
        IDX_STATUS: begin
          // a completion in the same cycle keeps the flag set
          if (apb_req.pwdata[ST_DONE] && !(q.busy && q.cnt == '0)) begin
            d.done = 1'b0;
          end
        end
        default: d.done = q.done;
      endcase
    end

    // latches go to the applied copy before the processor leaves reset
    unique case (q.boot)
      BOOT_HOLD: d.boot = BOOT_LOAD;
      BOOT_LOAD: begin
        d.applied = q.latch;                                          // [RULE_11] [RULE_19]
        d.boot    = BOOT_RUN;
      end
      BOOT_RUN:  d.boot = BOOT_RUN;
      default:   d.boot = BOOT_HOLD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      // control state restarts; stored bytes and latches persist unless nv_factory_init is set.
      // a reset mid write drops the row, which is why it must be avoided
      q.rowbuf       <= '0;
      q.row          <= '0;
      q.idx          <= '0;
      q.busy         <= 1'b0;                                         // [RULE_09]
      q.erase        <= 1'b0;
      q.done         <= 1'b0;
      q.cnt          <= '0;
      q.boot         <= BOOT_HOLD;                                    // [RULE_19]
      q.prdata       <= '0;
      q.pslverr      <= 1'b0;
      q.rd_data      <= '0;
      q.rd_valid     <= 1'b0;
      q.rd_fetch_err <= 1'b0;
      q.applied      <= q.applied;
      q.mem          <= q.mem;
      q.latch        <= q.latch;
      if (nv_factory_init) begin
        q.mem     <= '0;                                              // [RULE_05]
        q.latch   <= {LATCH3_RST, LATCH2_RST, LATCH1_RST, LATCH0_RST};
        q.applied <= {LATCH3_RST, LATCH2_RST, LATCH1_RST, LATCH0_RST};
      end
    end else begin
      q <= d;
    end
  end

  assign apb_rsp.pready  = access;
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pslverr = access & q.pslverr;

  assign rd_data        = q.rd_data;
  assign rd_valid       = q.rd_valid;
  assign rd_fetch_err   = q.rd_fetch_err;
  assign store_busy     = q.busy;
  assign cpu_reset_hold = (q.boot != BOOT_RUN);                       // [RULE_19]

  // one two-bit field per port, driving every pin of it
  always_comb begin
    boot_cfg.port_reset_drive_mode[0] = q.applied[0][1:0];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[1] = q.applied[0][3:2];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[2] = q.applied[0][5:4];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[3] = q.applied[0][7:6];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[4] = q.applied[1][1:0];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[5] = q.applied[1][3:2];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[6] = q.applied[1][5:4];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[7] = q.applied[1][7:6];            // [RULE_12]
    boot_cfg.port_reset_drive_mode[8] = q.applied[2][B2_P15+1:B2_P15]; // [RULE_12]
    boot_cfg.ext_reset_pin_select     = q.applied[2][B2_EXTERNAL_RESET_PIN];        // [RULE_13]
    boot_cfg.debug_access_enable      = q.applied[2][B2_DBG];         // [RULE_14]
    boot_cfg.debug_port_select        = q.applied[3][B3_DPS+1:B3_DPS]; // [RULE_15]
    // a port is live only with debug access on
    boot_cfg.jtag5_enable = boot_cfg.debug_access_enable &
                            (boot_cfg.debug_port_select == DPS_JTAG5);  // [RULE_15]
    boot_cfg.jtag4_enable = boot_cfg.debug_access_enable &
                            (boot_cfg.debug_port_select == DPS_JTAG4);  // [RULE_15]
    boot_cfg.swd_enable   = boot_cfg.debug_access_enable &
                            (boot_cfg.debug_port_select == DPS_SWD);    // [RULE_15]
    // correction itself lives in the flash cache path
    boot_cfg.ecc_region_enable         = q.applied[3][B3_ECC];         // [RULE_16] [RULE_20]
    boot_cfg.digital_clock_phase_delay = q.applied[3][B3_PHS+3:B3_PHS]; // [RULE_17]
  end

endmodule

// ==== verilog/eecl_pkg.sv ====
// package for the nonvolatile byte store and configuration latch block
// assumes a 20 MHz clock and an APB master with 32-bit data
package eecl_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned WRITE_TIME_MS = 20;
  localparam int unsigned WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);

  localparam int unsigned ROWS      = 128;
  localparam int unsigned ROW_BYTES = 16;
  localparam int unsigned ADDR_W    = 11;
  localparam int unsigned PADDR_W   = 12;
  localparam int unsigned CNT_W     = 32;
  localparam int unsigned PORTS     = 9;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_LATCH0 = 10'h000;
  localparam logic [9:0] IDX_LATCH1 = 10'h001;
  localparam logic [9:0] IDX_LATCH2 = 10'h002;
  localparam logic [9:0] IDX_LATCH3 = 10'h003;
  localparam logic [9:0] IDX_ROW    = 10'h004;
  localparam logic [9:0] IDX_DATA   = 10'h005;
  localparam logic [9:0] IDX_CMD    = 10'h006;
  localparam logic [9:0] IDX_STATUS = 10'h007;

  localparam logic [1:0] CMD_ERASE = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;

  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_IDX  = 8;

  // factory latch values
  localparam logic [7:0] LATCH0_RST = 8'h00;
  localparam logic [7:0] LATCH1_RST = 8'h00;
  localparam logic [7:0] LATCH2_RST = 8'h40;
  localparam logic [7:0] LATCH3_RST = 8'h09;
  localparam logic [7:0] MEM_RST    = 8'h00;

  // latch field positions
  localparam int unsigned B2_EXTERNAL_RESET_PIN   = 7;
  localparam int unsigned B2_DBG    = 6;
  localparam int unsigned B2_P15    = 2;
  localparam int unsigned B3_PHS    = 4;
  localparam int unsigned B3_ECC    = 3;
  localparam int unsigned B3_DPS    = 0;

  localparam logic [1:0] DPS_JTAG5 = 2'h0;
  localparam logic [1:0] DPS_JTAG4 = 2'h1;
  localparam logic [1:0] DPS_SWD   = 2'h2;
  localparam logic [1:0] DPS_OFF   = 2'h3;

  localparam logic [1:0] RDM_ANALOG_HIZ  = 2'h0;
  localparam logic [1:0] RDM_DIGITAL_HIZ = 2'h1;
  localparam logic [1:0] RDM_PULL_UP     = 2'h2;
  localparam logic [1:0] RDM_PULL_DOWN   = 2'h3;

  typedef enum logic [1:0] {
    BOOT_HOLD = 2'b00,
    BOOT_LOAD = 2'b01,
    BOOT_RUN  = 2'b11
  } eecl_boot_e;

  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
  } eecl_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } eecl_apb_rsp_s;

  typedef struct packed {
    logic [PORTS-1:0][1:0] port_reset_drive_mode;
    logic                  ext_reset_pin_select;
    logic                  debug_access_enable;
    logic [1:0]            debug_port_select;
    logic                  jtag5_enable;
    logic                  jtag4_enable;
    logic                  swd_enable;
    logic                  ecc_region_enable;
    logic [3:0]            digital_clock_phase_delay;
  } eecl_boot_cfg_s;

  typedef struct packed {
    logic [ROWS-1:0][ROW_BYTES-1:0][7:0] mem;
    logic [3:0][7:0]                     latch;
    logic [3:0][7:0]                     applied;
    logic [ROW_BYTES-1:0][7:0]           rowbuf;
    logic [6:0]                          row;
    logic [3:0]                          idx;
    logic                                busy;
    logic                                erase;
    logic                                done;
    logic [CNT_W-1:0]                    cnt;
    eecl_boot_e                          boot;
    logic [31:0]                         prdata;
    logic                                pslverr;
    logic [7:0]                          rd_data;
    logic                                rd_valid;
    logic                                rd_fetch_err;
  } eecl_state_s;
endpackage

// ==== testbench/eecl_sva.sv ====
// checker for the byte store and boot latch block
// sees only the top ports; bound from the testbench file
`timescale 1ns/1ps
module eecl_sva
  import eecl_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
  input wire logic           clock,
  input wire logic           reset,
  input wire logic           nv_factory_init,
  input wire eecl_apb_req_s  apb_req,
  input wire eecl_apb_rsp_s  apb_rsp,
  input wire logic           rd_en,
  input wire logic           rd_fetch,
  input wire logic [10:0]    rd_addr,
  input wire logic [7:0]     rd_data,
  input wire logic           rd_valid,
  input wire logic           rd_fetch_err,
  input wire logic           store_busy,
  input wire logic           cpu_reset_hold,
  input wire eecl_boot_cfg_s boot_cfg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic        acc;
  logic        cmd;
  logic [31:0] bcnt_q;
  assign acc = apb_req.psel && apb_req.penable;
  assign cmd = acc && apb_req.pwrite && apb_req.paddr == 12'h018;
  // counts busy cycles so the full write time is checked, not a window
  always_ff @(posedge clock) bcnt_q <= store_busy ? bcnt_q + 32'h0000_0001 : 32'h0000_0000;
  property p_ready; apb_rsp.pready == acc; endproperty
  a_ready: assert property (p_ready) else $error("pready not tied to access");
  property p_rvalid; rd_valid == $past(rd_en); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer count wrong");
  property p_fetch; rd_en && rd_fetch |=> rd_fetch_err && rd_data == 8'h00; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not refused");
  property p_ferr; rd_fetch_err == $past(rd_en && rd_fetch); endproperty
  a_ferr: assert property (p_ferr) else $error("fetch error without fetch");
  property p_hold;
    $fell(reset) |-> cpu_reset_hold ##1 cpu_reset_hold ##1 !cpu_reset_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("processor release timing");
  property p_cfg; !cpu_reset_hold && !$past(cpu_reset_hold) |-> $stable(boot_cfg); endproperty
  a_cfg: assert property (p_cfg) else $error("boot settings moved in run");
  property p_busy;
    bcnt_q <= WRITE_CYCLES_P && ($fell(store_busy) -> bcnt_q == WRITE_CYCLES_P);
  endproperty
  a_busy: assert property (p_busy) else $error("row write length wrong");
  // refusal is decided from busy as it stood in the setup cycle
  property p_cmd;
    cmd && !$past(store_busy) && apb_req.pwdata inside {32'h0000_0001, 32'h0000_0002}
      |=> store_busy;
  endproperty
  a_cmd: assert property (p_cmd) else $error("row command not started");
  property p_cmdbusy; cmd && store_busy |-> apb_rsp.pslverr; endproperty
  a_cmdbusy: assert property (p_cmdbusy) else $error("command during write taken");
  property p_addr;
    acc && (apb_req.paddr > 12'h01C || apb_req.paddr[1:0] != 2'h0) |-> apb_rsp.pslverr;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address not refused");
endmodule

// ==== testbench/eecl_cpu_model.sv ====
// processor side model: byte reads and fetches on the store read port
// assumes callers enter its task just after a rising clock edge
`timescale 1ns/1ps
module eecl_cpu_model (
  input  wire logic       clock,
  output logic            rd_en,
  output logic            rd_fetch,
  output logic [10:0]     rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  input  wire logic       rd_fetch_err
);
  initial begin
    rd_en = 1'b0;
    rd_fetch = 1'b0;
    rd_addr = 11'h000;
  end
  task automatic rd(input logic [10:0] a, input logic f, output logic [7:0] d,
                    output logic v, output logic e);
    rd_en <= 1'b1;
    rd_fetch <= f;
    rd_addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    rd_fetch <= 1'b0;
    rd_addr <= ~a; // stale address must not look like a hit
    @(posedge clock);
    d = rd_data;
    v = rd_valid;
    e = rd_fetch_err;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench: apb register tasks plus processor read model
// assumes write time shortened to 8 cycles
`timescale 1ns/1ps
module testbench;
  import eecl_pkg::*;
  logic            clock, reset, nv_init, rd_en, rd_fetch, rd_valid, rd_ferr, busy, hold, e, v;
  eecl_apb_req_s   req;
  eecl_apb_rsp_s   rsp;
  logic [10:0]     rd_addr;
  logic [7:0]      rd_data, b;
  logic [31:0]     r;
  logic [3:0][7:0] cur;
  eecl_boot_cfg_s  cfg;
  int              n_errors = 0;
  int              comparisons = 0;
  int              cyc = 0;
  eecl_top #(.WRITE_CYCLES_P(8)) i_dut (
    .clock(clock), .reset(reset), .nv_factory_init(nv_init), .apb_req(req), .apb_rsp(rsp),
    .rd_en(rd_en), .rd_fetch(rd_fetch), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_fetch_err(rd_ferr), .store_busy(busy), .cpu_reset_hold(hold),
    .boot_cfg(cfg));
  eecl_cpu_model i_cpu (.clock(clock), .rd_en(rd_en), .rd_fetch(rd_fetch), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_fetch_err(rd_ferr));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic mrd(input logic [10:0] a, input logic [7:0] x);
    i_cpu.rd(a, 1'b0, b, v, e);
    chk("rd_valid", 32'(v), 32'h1);
    chk("rd_data", 32'(b), 32'(x));
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 20 && busy === 1'b1; k++) @(posedge clock);
    chk("busy", 32'(busy), 32'h0);
  endtask
  task automatic rst(input logic f);
    // busy is unknown before the first reset edge; resets come only from here
    if (reset !== 1'b1) wait_idle();
    nv_init <= f;
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    nv_init <= 1'b0;
    repeat (3) @(posedge clock);
    chk("hold", 32'(hold), 32'h0);
  endtask
  function automatic eecl_boot_cfg_s ecfg(input logic [3:0][7:0] l);
    eecl_boot_cfg_s c;
    for (int k = 0; k < 8; k++) c.port_reset_drive_mode[k] = l[k/4][2*(k%4)+:2];
    c.port_reset_drive_mode[8] = l[2][3:2];
    c.ext_reset_pin_select = l[2][7];
    c.debug_access_enable = l[2][6];
    c.debug_port_select = l[3][1:0];
    c.jtag5_enable = l[2][6] && l[3][1:0] == DPS_JTAG5;
    c.jtag4_enable = l[2][6] && l[3][1:0] == DPS_JTAG4;
    c.swd_enable = l[2][6] && l[3][1:0] == DPS_SWD;
    c.ecc_region_enable = l[3][3];
    c.digital_clock_phase_delay = l[3][7:4];
    return c;
  endfunction
  task automatic setl(input logic [3:0][7:0] l);
    for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 * i), {24'h00_0000, l[i]});
    chk("cfg_early", 32'(cfg), 32'(ecfg(cur)));
    rst(1'b0);
    cur = l;
    chk("cfg", 32'(cfg), 32'(ecfg(l)));
  endtask
  initial begin
    reset = 1'b1;
    nv_init = 1'b1;
    req = '0;
    rst(1'b1);
    cur = {8'h09, 8'h40, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      chk("latch", r, 32'(cur[i]));
    end
    chk("cfg_factory", 32'(cfg), 32'(ecfg(cur)));
    mrd(11'h000, 8'h00);
    mrd(11'h7FF, 8'h00);
    $display("factory test done");
    apb(1'b1, 12'h010, 32'h0000_007F);
    for (int i = 0; i < 16; i++) apb(1'b1, 12'h014, 32'(8'hA0 + i));
    apb(1'b1, 12'h018, 32'h0000_0002);
    chk("cmd_err", 32'(e), 32'h0);
    mrd(11'h7F0, 8'h00);
    apb(1'b1, 12'h018, 32'h0000_0001);
    chk("cmd_busy_err", 32'(e), 32'h1);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("status_busy", r, 32'h0000_0001);
    wait_idle();
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("status_done", r, 32'h0000_0002);
    apb(1'b1, 12'h01C, 32'h0000_0002);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("status_clr", r, 32'h0000_0000);
    for (int i = 0; i < 16; i++) mrd(11'(12'h7F0 + i), 8'(8'hA0 + i));
    mrd(11'h7EF, 8'h00);
    i_cpu.rd(11'h7F0, 1'b1, b, v, e);
    chk("fetch_data", 32'(b), 32'h0);
    chk("fetch_err", 32'(e), 32'h1);
    $display("row test done");
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("err_top", 32'(e), 32'h1);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("err_unmapped", 32'(e), 32'h1);
    apb(1'b0, 12'h002, 32'h0000_0000);
    chk("err_unaligned", 32'(e), 32'h1);
    apb(1'b1, 12'h018, 32'h0000_0003);
    chk("err_cmd", 32'(e), 32'h1);
    $display("error test done");
    setl({8'h52, 8'h8C, 8'h1B, 8'hE4});
    // few rewrites: latch endurance is limited
    for (int d = 0; d < 4; d++) setl({8'(8'hA8 + d), 8'h40, 8'h1B, 8'hE4});
    mrd(11'h7F5, 8'hA5);
    // reset cleared the row register, so select the row again
    apb(1'b1, 12'h010, 32'h0000_007F);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("row", r, 32'h0000_007F);
    apb(1'b1, 12'h014, 32'h0000_0055);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("status_idx", r, 32'h0000_0100);
    apb(1'b1, 12'h018, 32'h0000_0001);
    wait_idle();
    mrd(11'h7F5, 8'h00);
    $display("latch test done");
    print_verdict();
  end
endmodule
bind eecl_top eecl_sva #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) i_sva (
  .clock(clock), .reset(reset), .nv_factory_init(nv_factory_init), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .rd_en(rd_en), .rd_fetch(rd_fetch), .rd_addr(rd_addr), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_fetch_err(rd_fetch_err), .store_busy(store_busy),
  .cpu_reset_hold(cpu_reset_hold), .boot_cfg(boot_cfg));
